// [bcss_bus_status.sv]
// Bus cycle status, write strobes, queue status and memory selects
`timescale 1ns/100ps
`default_nettype none
`include "bcss_regs.svh"
module bcss_bus_status #(
    parameter int ADDR_W = 20
)(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Core cycle request
    input wire logic i_cyc_start,
    input wire logic [2:0] i_cyc_type,
    input wire logic [ADDR_W-1:0] i_cyc_addr,
    input wire logic i_byte_high_enable_n,
    input wire logic i_muxed_addr_bit_zero,
    input wire logic i_cyc_last,
    // Queue activity
    input wire logic i_q_first,
    input wire logic i_q_init,
    input wire logic i_q_next,
    // Hold
    input wire logic i_hold_req,
    // Region configuration
    input wire logic [ADDR_W-1:0] i_lower_base,
    input wire logic [ADDR_W-1:0] i_lower_mask,
    input wire logic [ADDR_W-1:0] i_mid_base,
    input wire logic [ADDR_W-1:0] i_mid_mask,
    input wire logic [1:0] i_mid_sub_shift,
    input wire logic i_mid_zero_whole,
    input wire logic i_lower_bus8,
    input wire logic i_mid_bus8,
    // Status and strobes
    output logic [2:0] o_bus_cycle_status_lines,
    output logic o_status_oe_n,
    output logic o_write_strobe_n,
    output logic o_write_high_byte_strobe_n,
    output logic o_write_low_byte_strobe_n,
    output logic o_strobe_oe_n,
    output logic [1:0] o_byte_code,
    output logic o_refresh_cycle,
    // Selects
    output logic o_lower_memory_select_n,
    output logic [3:0] o_midrange_memory_selects_n,
    output logic o_select_oe_n,
    output logic o_bus_size8,
    // Queue and hold
    output logic [1:0] o_queue_activity_lines,
    output logic o_hold_acknowledge,
    output logic o_busy
);
    bcss_pkg::bcss_state_e state_reg, state_next;
    logic [2:0] type_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic bhe_n_reg, a0_reg;
    logic [1:0] qs_reg;
    logic lcs_reg;
    logic [3:0] mcs_reg;

    // ****************************************
    // Decode
    // ****************************************
    wire is_mem = type_reg[`BCSS_ST_MEM_BIT];
    wire is_wr = type_reg[`BCSS_ST_DIR_BIT] & ~type_reg[0];
    wire active = (state_reg == bcss_pkg::BCSS_ADDR) || (state_reg == bcss_pkg::BCSS_DATA);
    wire take_start = (state_reg == bcss_pkg::BCSS_IDLE) && (state_next == bcss_pkg::BCSS_ADDR);
    // Lower match works on the incoming request so the select can ride the address phase
    wire in_lower = i_cyc_type[`BCSS_ST_MEM_BIT] &&
                    ((i_cyc_addr & ~i_lower_mask) == (i_lower_base & ~i_lower_mask));
    wire in_mid = is_mem && ((addr_reg & ~i_mid_mask) == (i_mid_base & ~i_mid_mask));
    wire [ADDR_W-1:0] mid_off = (addr_reg & i_mid_mask) >> i_mid_sub_shift;
    wire [ADDR_W-1:0] mid_q = i_mid_mask >> i_mid_sub_shift;
    // Last offset of the third quarter, so the fourth quarter starts exactly on its boundary
    wire [ADDR_W-1:0] mid_q3 = (mid_q >> 1) + (mid_q >> 2) + {{(ADDR_W-1){1'b0}}, 1'b1};
    wire [1:0] mid_idx = (mid_off > (mid_q >> 1)) ? ((mid_off > mid_q3) ? 2'h3 : 2'h2)
                       : ((mid_off > (mid_q >> 2)) ? 2'h1 : 2'h0);
    wire [1:0] mid_sel_idx = i_mid_zero_whole ? 2'h0 : mid_idx;
    wire hold_state = (state_reg == bcss_pkg::BCSS_HOLD);

    // ****************************************
    // Cycle sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            bcss_pkg::BCSS_IDLE:
            begin
                if (i_hold_req)
                    state_next = bcss_pkg::BCSS_HOLD;
                else if (i_cyc_start)
                    state_next = bcss_pkg::BCSS_ADDR;
            end
            bcss_pkg::BCSS_ADDR: state_next = bcss_pkg::BCSS_DATA;
            bcss_pkg::BCSS_DATA:
            begin
                if (i_cyc_last)
                    state_next = i_hold_req ? bcss_pkg::BCSS_HOLD : bcss_pkg::BCSS_IDLE;
            end
            bcss_pkg::BCSS_HOLD:
            begin
                if (!i_hold_req)
                    state_next = bcss_pkg::BCSS_IDLE;
            end
            default: state_next = bcss_pkg::BCSS_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= bcss_pkg::BCSS_IDLE;
            type_reg <= `BCSS_ST_PASSIVE;
            addr_reg <= '0;
            bhe_n_reg <= 1'b1;
            a0_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == bcss_pkg::BCSS_IDLE && state_next == bcss_pkg::BCSS_ADDR)
            begin
                type_reg <= i_cyc_type;
                addr_reg <= i_cyc_addr;
                bhe_n_reg <= i_byte_high_enable_n;
                a0_reg <= i_muxed_addr_bit_zero;
            end
            else if (state_next == bcss_pkg::BCSS_IDLE || state_next == bcss_pkg::BCSS_HOLD)
                type_reg <= `BCSS_ST_PASSIVE;
        end
    end

    // ****************************************
    // Selects and queue status
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            lcs_reg <= 1'b0;
            mcs_reg <= 4'h0;
            qs_reg <= `BCSS_QS_NONE;
        end
        else
        begin
            // Lower select spans address and data phase, midranges only the data phase
            lcs_reg <= take_start ? in_lower : (lcs_reg && state_next == bcss_pkg::BCSS_DATA);
            mcs_reg <= (state_next == bcss_pkg::BCSS_DATA && in_mid) ? (4'h1 << mid_sel_idx) : 4'h0;
            if (i_q_init)
                qs_reg <= `BCSS_QS_INIT;
            else if (i_q_first)
                qs_reg <= `BCSS_QS_FIRST;
            else if (i_q_next)
                qs_reg <= `BCSS_QS_NEXT;
            else
                qs_reg <= `BCSS_QS_NONE;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic wr_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wr_reg <= 1'b0;
        else
            wr_reg <= (state_next == bcss_pkg::BCSS_DATA) && (state_reg != bcss_pkg::BCSS_IDLE) && is_wr;
    end

    assign o_bus_cycle_status_lines = type_reg;
    assign o_status_oe_n = ~i_rst_n | hold_state;
    assign o_write_strobe_n = ~wr_reg;
    assign o_write_high_byte_strobe_n = bhe_n_reg | ~wr_reg;
    assign o_write_low_byte_strobe_n = a0_reg | ~wr_reg;
    assign o_strobe_oe_n = ~i_rst_n | hold_state;
    assign o_byte_code = {bhe_n_reg, a0_reg};
    assign o_refresh_cycle = active && bhe_n_reg && a0_reg;
    assign o_lower_memory_select_n = ~lcs_reg;
    assign o_midrange_memory_selects_n = ~mcs_reg;
    assign o_select_oe_n = ~i_rst_n | hold_state;
    assign o_bus_size8 = (lcs_reg & i_lower_bus8) | ((|mcs_reg) & i_mid_bus8);
    assign o_queue_activity_lines = qs_reg;
    assign o_hold_acknowledge = hold_state;
    assign o_busy = active;

    // ****************************************
    // Assertions
    // ****************************************
    AST_WR_IN_DATA: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !o_write_strobe_n |-> o_bus_cycle_status_lines inside {`BCSS_ST_IO_WR, `BCSS_ST_MEM_WR})
        else $error("Write strobe outside a write cycle");
    AST_WHB_AND: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_write_high_byte_strobe_n == (o_byte_code[1] | o_write_strobe_n))
        else $error("High byte strobe mismatch");
    AST_WLB_AND: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_write_low_byte_strobe_n == (o_byte_code[0] | o_write_strobe_n))
        else $error("Low byte strobe mismatch");
    AST_HOLD_FLOAT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_hold_acknowledge |-> o_status_oe_n && o_strobe_oe_n && o_select_oe_n)
        else $error("Outputs driven during hold");
    AST_QS_NONE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !(i_q_first | i_q_init | i_q_next) |=> o_queue_activity_lines == `BCSS_QS_NONE)
        else $error("Queue status not idle");
    AST_QS_INIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_q_init |=> o_queue_activity_lines == `BCSS_QS_INIT)
        else $error("Queue init not shown");
    AST_MID_ONEHOT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $onehot0(~o_midrange_memory_selects_n))
        else $error("More than one midrange select");
    AST_MID_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_mid_zero_whole && $stable(i_mid_zero_whole) |-> o_midrange_memory_selects_n[3:1] == 3'h7)
        else $error("Whole range mode used upper selects");
    AST_HOLD_ACK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == bcss_pkg::BCSS_IDLE) && i_hold_req |=> o_hold_acknowledge)
        else $error("Hold not acknowledged");
    AST_MID_LATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(o_busy) |-> o_midrange_memory_selects_n == 4'hF)
        else $error("Midrange select in address phase");
    COV_WRITE: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) !o_write_strobe_n);
    COV_HOLD: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $rose(o_hold_acknowledge));
    COV_LOWER: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) !o_lower_memory_select_n);
    COV_MID3: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) !o_midrange_memory_selects_n[3]);
endmodule
`default_nettype wire

// [bcss_regs.svh]
// Constants for the bus cycle status and memory select block
// Notes on behaviour
// - Status lines encode cycle: 0 reserved,1 io rd,2 io wr,3 halt,4 fetch,5 mem rd,6 mem wr,7 passive.
// - Top status bit marks memory versus I/O; middle bit marks transmit versus receive.
// - Status lines float in hold, float with pullup during reset.
// - High byte write strobe is AND of active-low byte enable and write strobe.
// - Low byte write strobe is AND of address bit zero and write strobe.
// - Write strobe asserts when bus data is to be written.
// - Write strobe floats with pullup in hold or reset.
// - Lower select asserts for memory accesses inside programmable lower block up to 512 Kbyte; the code does not limit i_lower_mask to that size.
// - Lower and midrange regions each choose 8-bit or 16-bit bus width.
// - Lower select floats with pullup in hold or reset.
// - Each of four midrange selects asserts for accesses to its own sub-region.
// - Midrange selects float with pullups in hold or reset.
// - A setting lets midrange select zero cover the whole midrange range.
// - Midrange selects follow muxed bus timing; lower select follows earlier address timing.
// - Queue lines: 01 first opcode byte, 10 queue initialised, 11 subsequent byte.
// - Byte enable and bit zero: 00 word, 01 high byte, 10 low byte, 11 refresh.
// - On hold request finish current cycle, then acknowledge until request withdrawn.
`ifndef BCSS_REGS_SVH
`define BCSS_REGS_SVH
`define BCSS_ST_RESERVED 3'h0
`define BCSS_ST_IO_RD 3'h1
`define BCSS_ST_IO_WR 3'h2
`define BCSS_ST_HALT 3'h3
`define BCSS_ST_FETCH 3'h4
`define BCSS_ST_MEM_RD 3'h5
`define BCSS_ST_MEM_WR 3'h6
`define BCSS_ST_PASSIVE 3'h7
`define BCSS_ST_MEM_BIT 2
`define BCSS_ST_DIR_BIT 1
`define BCSS_QS_NONE 2'h0
`define BCSS_QS_FIRST 2'h1
`define BCSS_QS_INIT 2'h2
`define BCSS_QS_NEXT 2'h3
`define BCSS_LOWER_MAX_BYTES 20'h80000
`endif

// [bcss_pkg.sv]
// Types for the bus cycle status and memory select block
`default_nettype none
package bcss_pkg;
    typedef enum logic [3:0] {
        BCSS_IDLE = 4'h1,
        BCSS_ADDR = 4'h2,
        BCSS_DATA = 4'h4,
        BCSS_HOLD = 4'h8
    } bcss_state_e;
endpackage
`default_nettype wire

// [bcss_ext_master.sv]
// Board side model: pullups on released pins and an external master that asks for the bus
`timescale 1ns/100ps
`default_nettype none
module bcss_ext_master (
    // Clock and bus ownership
    input wire logic i_sys_clk,
    input wire logic i_want_bus,
    output logic o_hold_req,
    // Device pins and their drive enables
    input wire logic [2:0] i_status,
    input wire logic i_status_oe_n,
    input wire logic [2:0] i_strobes_n,
    input wire logic i_strobe_oe_n,
    input wire logic [4:0] i_selects_n,
    input wire logic i_select_oe_n,
    // Levels seen on the board
    output logic [2:0] o_pin_status,
    output logic [2:0] o_pin_strobes_n,
    output logic [4:0] o_pin_selects_n
);
    // Released pins float up to the pullup level
    assign o_pin_status = i_status_oe_n ? 3'h7 : i_status;
    assign o_pin_strobes_n = i_strobe_oe_n ? 3'h7 : i_strobes_n;
    assign o_pin_selects_n = i_select_oe_n ? 5'h1F : i_selects_n;
    // Request stays up for as long as the master wants the bus
    always @(posedge i_sys_clk)
        o_hold_req <= i_want_bus;
endmodule
`default_nettype wire

// [bcss_bus_status_tb.sv]
// Self-checking bench for the bus cycle status and memory select block
`timescale 1ns/100ps
`default_nettype none
module bcss_bus_status_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, cyc_start = 1'b0, bhe_n = 1'b0, a0 = 1'b0, cyc_last = 1'b0;
    logic q_first = 1'b0, q_init = 1'b0, q_next = 1'b0, want_bus = 1'b0, mid_whole = 1'b0, lower_b8 = 1'b0, mid_b8 = 1'b0;
    logic [2:0] cyc_type = 3'h0;
    logic [19:0] cyc_addr = 20'h00000;
    logic [19:0] lower_base = 20'h00000;
    logic [1:0] sub_shift = 2'h0;
    logic [2:0] status, pin_status, pin_strb;
    logic status_oe_n, wr_n, whb_n, wlb_n, strobe_oe_n, refresh, lcs_n, select_oe_n, size8, hold_ack, busy, hold_req;
    logic [3:0] mcs_n;
    logic [1:0] byte_code, qs, ph = 2'h0;
    logic [4:0] pin_sels;
    logic [6:0] exp_a [$];
    logic [7:0] exp_d [$];
    logic [1:0] exp_q [$];
    int n_errors = 0, n_checks = 0, seed = 70108;
    always #12.5 sys_clk = ~sys_clk;
    bcss_bus_status bcss_bus_status_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cyc_start(cyc_start),
        .i_cyc_type(cyc_type), .i_cyc_addr(cyc_addr), .i_byte_high_enable_n(bhe_n), .i_muxed_addr_bit_zero(a0),
        .i_cyc_last(cyc_last), .i_q_first(q_first), .i_q_init(q_init), .i_q_next(q_next), .i_hold_req(hold_req),
        .i_lower_base(lower_base), .i_lower_mask(20'h0FFFF), .i_mid_base(20'h80000), .i_mid_mask(20'h3FFFF),
        .i_mid_sub_shift(sub_shift), .i_mid_zero_whole(mid_whole), .i_lower_bus8(lower_b8), .i_mid_bus8(mid_b8),
        .o_bus_cycle_status_lines(status), .o_status_oe_n(status_oe_n), .o_write_strobe_n(wr_n),
        .o_write_high_byte_strobe_n(whb_n), .o_write_low_byte_strobe_n(wlb_n), .o_strobe_oe_n(strobe_oe_n),
        .o_byte_code(byte_code), .o_refresh_cycle(refresh), .o_lower_memory_select_n(lcs_n),
        .o_midrange_memory_selects_n(mcs_n), .o_select_oe_n(select_oe_n), .o_bus_size8(size8),
        .o_queue_activity_lines(qs), .o_hold_acknowledge(hold_ack), .o_busy(busy));
    bcss_ext_master bcss_ext_master_inst (.i_sys_clk(sys_clk), .i_want_bus(want_bus), .o_hold_req(hold_req),
        .i_status(status), .i_status_oe_n(status_oe_n), .i_strobes_n({wr_n, whb_n, wlb_n}),
        .i_strobe_oe_n(strobe_oe_n), .i_selects_n({lcs_n, mcs_n}), .i_select_oe_n(select_oe_n),
        .o_pin_status(pin_status), .o_pin_strobes_n(pin_strb), .o_pin_selects_n(pin_sels));
    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_ack(input logic lvl);
        int k;
        k = 0;
        while (hold_ack !== lvl && k < 5)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check("hold acknowledge", {7'h00, hold_ack}, {7'h00, lvl});
        if (hold_ack !== lvl)
            wrap_up();
    endtask
    task automatic run_cyc(input logic [2:0] t, input logic [19:0] a);
        logic [3:0] m;
        logic l, w, hb, lb, mem;
        hb = 1'($random(seed));
        lb = 1'($random(seed));
        mem = (t == 3'h5) || (t == 3'h6);
        w = (t == 3'h2) || (t == 3'h6);
        l = !(mem && a[19:16] == lower_base[19:16]);
        m = (mem && a[19:18] == 2'b10) ? (mid_whole ? 4'hE : ~(4'h1 << a[17:16])) : 4'hF;
        exp_a.push_back({t, l, hb, lb, hb & lb});
        exp_d.push_back({m, !w, hb | !w, lb | !w, (!l & lower_b8) | ((m != 4'hF) & mid_b8)});
        cyc_start <= 1'b1;
        cyc_type <= t;
        cyc_addr <= a;
        bhe_n <= hb;
        a0 <= lb;
        @(posedge sys_clk);
        cyc_start <= 1'b0;
        @(posedge sys_clk);
        cyc_last <= 1'b1;
        @(posedge sys_clk);
        cyc_last <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    // ****************************************
    // Output watcher
    // ****************************************
    always @(negedge sys_clk)
    begin
        if (rst_n && ph == 2'h0 && pin_status !== 3'h7)
            check("address phase", {busy, pin_status, pin_sels[4], byte_code, refresh}, {1'b1, exp_a.pop_front()});
        if (ph == 2'h1)
            check("data phase", {pin_sels[3:0], pin_strb, size8}, exp_d.pop_front());
        if (rst_n && qs !== 2'h0)
            check("queue status", {6'h00, qs}, {6'h00, exp_q.pop_front()});
        ph <= (pin_status === 3'h7 || !rst_n) ? 2'h0 : ((ph == 2'h0) ? 2'h1 : 2'h2);
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        check("reset pins", {pin_status, pin_strb, pin_sels[4], 1'b0}, 8'hFE);
        check("reset drive", {3'h0, status_oe_n, strobe_oe_n, select_oe_n, qs}, 8'h1C);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 42; i++)
        begin
            @(posedge sys_clk);
            mid_whole <= 1'($random(seed));
            lower_b8 <= 1'($random(seed));
            mid_b8 <= 1'($random(seed));
            sub_shift <= 2'($random(seed));
            lower_base <= {3'h0, 1'($random(seed)), 16'h0000};
            @(posedge sys_clk);
            run_cyc(3'(i % 7), (i % 7 < 5) ? {4'h4, 16'($random(seed))} : ((i / 7) % 3 == 0) ?
                {4'h0, 16'($random(seed))} : ((i / 7) % 3 == 1) ? {2'b10, 18'($random(seed))} : 20'h60000);
        end
        want_bus <= 1'b1;
        wait_ack(1'b1);
        check("hold release", {5'h00, status_oe_n, strobe_oe_n, select_oe_n}, 8'h07);
        @(posedge sys_clk);
        cyc_start <= 1'b1;
        @(posedge sys_clk);
        cyc_start <= 1'b0;
        want_bus <= 1'b0;
        wait_ack(1'b0);
        check("start refused in hold", {7'h00, busy}, 8'h00);
        @(posedge sys_clk);
        q_init <= 1'b1;
        q_first <= 1'b1;
        q_next <= 1'b1;
        exp_q.push_back(2'h2);
        @(posedge sys_clk);
        q_init <= 1'b0;
        exp_q.push_back(2'h1);
        @(posedge sys_clk);
        q_first <= 1'b0;
        exp_q.push_back(2'h3);
        @(posedge sys_clk);
        q_next <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("pending notes", 8'(exp_a.size() + exp_d.size() + exp_q.size()), 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
